// [tms_defines.svh]
// timing constants and configuration field layout of the measurement sequencer
`ifndef TMS_DEFINES_SVH
`define TMS_DEFINES_SVH
`define TMS_CLK_MHZ           200
`define TMS_EN_TRIG_NS        50
`define TMS_EN_TRIG_CYC       ((`TMS_EN_TRIG_NS * `TMS_CLK_MHZ + 999) / 1000)
`define TMS_RES_TRIG_NS       3050
`define TMS_RES_TRIG_CYC      ((`TMS_RES_TRIG_NS * `TMS_CLK_MHZ + 999) / 1000)
`define TMS_SCLK_MAX_MHZ      26
`define TMS_SCLK_HALF_CYC     ((`TMS_CLK_MHZ + 2 * `TMS_SCLK_MAX_MHZ - 1) / (2 * `TMS_SCLK_MAX_MHZ))
`define TMS_CFG_DIV_LSB       5
`define TMS_CFG_DIV_W         3
`define TMS_CFG_NUM_LSB       0
`define TMS_CFG_NUM_W         5
`define TMS_CFG_RESET         8'h45
`define TMS_START_MAX_PULSES  3
`endif

// [tms_device.sv]
// measurement sequencer: trigger, start pulse, transmit burst, stop pulses
// Summary of operation
// - cycle starts only on host trigger
// - one start pulse per trigger from idle; a trigger while listening gives none
// - burst begins with start pulse rising edge
// - start width one period per pulse, up to three
// - host waits 50 ns enable-to-trigger
// - host waits 3.05 us reset-to-trigger
// - receive detections after the burst give stop pulses
// - host measures start-to-stop interval
// - divider and pulse count loaded over serial
// - host serial clock at most 26 MHz
// - tx frequency is ref clock over 2^(div+1)
// - pulse count equals programmed field
`timescale 1ns/100ps
`include "tms_defines.svh"
module tms_device
  import tms_pkg::*;
#(
  parameter int DIV_W = `TMS_CFG_DIV_W,
  parameter int NUM_W = `TMS_CFG_NUM_W
)(
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic ref_clk_en_i,   // reference_clock_input tick
  input  wire logic rx_detect_i,    // receive chain echo crossing
  output logic      tx_pulse_o,     // transducer drive
  output logic      burst_busy_o,
  tms_if.dev        link
);
  localparam int CFG_W = DIV_W + NUM_W;

  tms_dev_state_t     state;
  logic [CFG_W-1:0]   shift;
  logic [DIV_W-1:0]   tx_divider_exponent;
  logic [NUM_W-1:0]   num_pulses;
  logic [15:0]        div_cnt;
  logic [NUM_W:0]     half_cnt;
  logic               trig_q;
  logic               sclk_q;
  logic               half_tick;
  logic               rst_all;

  assign rst_all = !rst_n_i || !link.dev_rst_n;

  // serial configuration, msb first, sampled on sclk rise, loaded on cs rise
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_all)
    begin
      shift               <= '0;
      tx_divider_exponent <= DIV_W'(`TMS_CFG_RESET >> `TMS_CFG_DIV_LSB);
      num_pulses          <= NUM_W'(`TMS_CFG_RESET >> `TMS_CFG_NUM_LSB);
      sclk_q              <= 1'b0;
    end
    else
    begin
      sclk_q <= link.sclk;
      if (!link.cs_n && link.sclk && !sclk_q)
        shift <= {shift[CFG_W-2:0], link.sdi};
      if (link.cs_n && state == TMS_IDLE && shift != '0)
      begin
        tx_divider_exponent <= shift[CFG_W-1 -: DIV_W];
        num_pulses          <= shift[NUM_W-1:0];
        shift               <= '0;
      end
    end
  end

  // half-period tick: 2^exp reference ticks per half period
  assign half_tick = ref_clk_en_i &&
                     (div_cnt ==
                      16'((32'h0000_0001 << tx_divider_exponent) - 1));
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_all || state == TMS_IDLE)
      div_cnt <= '0;
    else if (ref_clk_en_i)
      div_cnt <= half_tick ? 16'h0000 : div_cnt + 16'h0001;
  end

  // sequencing of one measurement
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_all)
    begin
      state    <= TMS_IDLE;
      half_cnt <= '0;
      trig_q   <= 1'b0;
    end
    else
    begin
      trig_q <= link.trigger;
      unique case (state)
        TMS_IDLE:
          if (link.enable && link.trigger && !trig_q && num_pulses != '0)
          begin
            state    <= TMS_BURST;
            half_cnt <= '0;
          end
        TMS_BURST:
          if (half_tick)
          begin
            if (half_cnt == (NUM_W+1)'({num_pulses, 1'b0} - 1))
              state <= TMS_LISTEN;
            half_cnt <= half_cnt + 1'b1;
          end
        TMS_LISTEN:
          if (!link.enable || (link.trigger && !trig_q))
            state <= TMS_IDLE;
      endcase
    end
  end

  // start high from burst begin for min(count,3) periods; tx high on even halves
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_all)
    begin
      link.start <= 1'b0;
      tx_pulse_o <= 1'b0;
    end
    else
    begin
      link.start <= (state == TMS_IDLE && link.enable && link.trigger &&
                     !trig_q && num_pulses != '0) ||
                    (state == TMS_BURST && link.start &&
                     !(half_tick && half_cnt ==
                       (NUM_W+1)'(2 * ((num_pulses < `TMS_START_MAX_PULSES) ?
                        num_pulses : `TMS_START_MAX_PULSES) - 1)));
      tx_pulse_o <= (state == TMS_IDLE && link.enable && link.trigger &&
                     !trig_q && num_pulses != '0) ||
                    (state == TMS_BURST &&
                     (half_tick ? half_cnt[0] : tx_pulse_o) &&
                     !(half_tick && half_cnt ==
                       (NUM_W+1)'({num_pulses, 1'b0} - 1)));
    end
  end

  // stop pulses follow receive detections after the burst
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_all)
      link.stop <= 1'b0;
    else
      link.stop <= (state == TMS_LISTEN) && rx_detect_i;
  end

  assign burst_busy_o = (state == TMS_BURST);
endmodule

// [tms_host.sv]
// timing host: configures over serial, triggers, measures start-to-stop
`timescale 1ns/100ps
`include "tms_defines.svh"
module tms_host
  import tms_pkg::*;
#(
  parameter int CFG_W   = `TMS_CFG_DIV_W + `TMS_CFG_NUM_W,
  parameter int RES_CYC = `TMS_RES_TRIG_CYC
)(
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [CFG_W-1:0] cfg_i,     // exponent and pulse count
  input  wire logic             measure_i, // request one measurement
  output logic                  ready_o,
  output logic [31:0]           flight_time_o,
  output logic                  flight_valid_o,
  tms_if.host                   link
);
  tms_host_state_t state;
  logic [15:0]     wait_cnt;
  logic [4:0]      bit_cnt;
  logic [CFG_W-1:0] sh;
  logic [31:0]     tof_cnt;
  logic            running;
  logic            got_stop;

  // link sequencing: reset, configure, enable, wait, trigger
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      state          <= TMS_H_RESET;
      wait_cnt       <= '0;
      bit_cnt        <= '0;
      sh             <= '0;
      link.dev_rst_n <= 1'b0;
      link.enable    <= 1'b0;
      link.trigger   <= 1'b0;
      link.sclk      <= 1'b0;
      link.cs_n      <= 1'b1;
      link.sdi       <= 1'b0;
    end
    else
    begin
      link.trigger <= 1'b0;
      unique case (state)
        TMS_H_RESET:
        begin
          link.dev_rst_n <= 1'b1;
          sh             <= cfg_i;
          wait_cnt       <= '0;
          bit_cnt        <= '0;
          link.cs_n      <= 1'b0;
          state          <= TMS_H_SPI;
        end
        TMS_H_SPI:
          if (wait_cnt == 16'(`TMS_SCLK_HALF_CYC - 1))
          begin
            wait_cnt  <= '0;
            link.sclk <= !link.sclk;
            if (link.sclk)
            begin
              bit_cnt <= bit_cnt + 5'h01;
              sh      <= {sh[CFG_W-2:0], 1'b0};
              if (bit_cnt == 5'(CFG_W - 1))
              begin
                link.cs_n   <= 1'b1;
                link.enable <= 1'b1;
                state       <= TMS_H_ENWAIT;
              end
            end
            else
              link.sdi <= sh[CFG_W-1];
          end
          else
            wait_cnt <= wait_cnt + 16'h0001;
        TMS_H_ENWAIT:
          if (wait_cnt == 16'(RES_CYC))
            state <= TMS_H_READY;
          else
            wait_cnt <= wait_cnt + 16'h0001;
        TMS_H_READY:
          if (measure_i)
          begin
            link.trigger <= 1'b1;
            state        <= TMS_H_WAIT;
          end
        TMS_H_WAIT:
          if (flight_valid_o)
            state <= TMS_H_READY;
      endcase
    end
  end

  assign ready_o = (state == TMS_H_READY);

  // count from start rising edge to first stop pulse
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      tof_cnt        <= '0;
      running        <= 1'b0;
      got_stop       <= 1'b0;
      flight_time_o  <= '0;
      flight_valid_o <= 1'b0;
    end
    else
    begin
      flight_valid_o <= 1'b0;
      if (link.start && !running && state == TMS_H_WAIT && !got_stop)
      begin
        running <= 1'b1;
        tof_cnt <= 32'h0000_0000;
      end
      else if (running)
      begin
        tof_cnt <= tof_cnt + 32'h0000_0001;
        if (link.stop)
        begin
          running        <= 1'b0;
          flight_time_o  <= tof_cnt + 32'h0000_0001;
          flight_valid_o <= 1'b1;
          got_stop       <= 1'b1;
        end
      end
      if (state == TMS_H_READY)
        got_stop <= 1'b0;
    end
  end
endmodule

// [tms_if.sv]
// pins between the sequencer device and its timing host
`timescale 1ns/100ps
interface tms_if;
  logic enable;
  logic trigger;
  logic dev_rst_n;
  logic start;
  logic stop;
  logic sclk;
  logic cs_n;
  logic sdi;
  modport dev  (input enable, trigger, dev_rst_n, sclk, cs_n, sdi,
                output start, stop);
  modport host (output enable, trigger, dev_rst_n, sclk, cs_n, sdi,
                input start, stop);
endinterface

// [tms_pkg.sv]
// shared types of the measurement sequencer
package tms_pkg;
  typedef enum logic [1:0] {TMS_IDLE, TMS_BURST, TMS_LISTEN} tms_dev_state_t;
  typedef enum logic [2:0] {TMS_H_RESET, TMS_H_SPI, TMS_H_ENWAIT, TMS_H_READY,
                            TMS_H_WAIT} tms_host_state_t;
endpackage

// [tms_props.sv]
// link assertions between timing host and sequencer
`timescale 1ns/100ps
module tms_props #(
  parameter int RES_CYC = 610
)(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic enable,
  input wire logic trigger,
  input wire logic dev_rst_n,
  input wire logic start,
  input wire logic stop,
  input wire logic sclk
);
  int en_cnt;
  int rst_cnt;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // saturating cycle counts since enable and device reset release
  always_ff @(posedge sys_clk_i)
  begin
    en_cnt <= (!rst_n_i || !enable) ? 0 : en_cnt + (en_cnt < 10);
    rst_cnt <= (!rst_n_i || !dev_rst_n) ? 0 : rst_cnt + (rst_cnt < RES_CYC);
  end
  // start rising edge
  sequence s_rise;
    !start ##1 start;
  endsequence
  property p_cause; s_rise |-> $past(trigger); endproperty
  property p_min; s_rise |=> start; endproperty
  property p_max; s_rise |-> ##[1:800] !start; endproperty
  property p_rst; !dev_rst_n |=> !start; endproperty
  property p_stop; start |-> !stop; endproperty
  property p_sclk; $rose(sclk) |-> sclk[*4]; endproperty
  property p_en; trigger |-> en_cnt >= 10; endproperty
  property p_res; trigger |-> rst_cnt >= RES_CYC; endproperty
  a_cause: assert property (p_cause) else $error("start without trigger");
  a_min: assert property (p_min) else $error("start too short");
  a_max: assert property (p_max) else $error("start too long");
  a_rst: assert property (p_rst) else $error("start during reset");
  a_stop: assert property (p_stop) else $error("stop during burst");
  a_sclk: assert property (p_sclk) else $error("serial clock fast");
  a_en: assert property (p_en) else $error("trigger too early");
  a_res: assert property (p_res) else $error("trigger after reset");
endmodule

// [tof_measurement_sequencer_tb.sv]
// bench: host and sequencer joined, one measurement per setting
`timescale 1ns/100ps
module tof_measurement_sequencer_tb;
  import tms_pkg::*;
  logic        sys_clk_i = 1'h0;
  logic        rst_n_i = 1'h0;
  logic        ref_en = 1'h1;
  logic        rx = 1'h0;
  logic [7:0]  cfg = 8'h45;
  logic        meas = 1'h0;
  logic        tx;
  logic        busy;
  logic        rdy;
  logic        fv;
  logic [31:0] ft;
  logic [31:0] ftv;
  logic        st_q;
  logic        tx_q;
  int          fails;
  int          num_checks;
  int          cyc;
  // 0 start cycles, 1 tx high, 2 tx rises, 3 starts, 4 stops, 5 skew, 6 done
  int          c [7];
  tms_if tms_if_inst ();
  wire logic   st = tms_if_inst.start;
  tms_device tms_device_inst (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .ref_clk_en_i(ref_en), .rx_detect_i(rx), .tx_pulse_o(tx),
    .burst_busy_o(busy), .link(tms_if_inst.dev));
  tms_host #(.RES_CYC(12)) tms_host_inst (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .cfg_i(cfg), .measure_i(meas), .ready_o(rdy),
    .flight_time_o(ft), .flight_valid_o(fv), .link(tms_if_inst.host));
  tms_props #(.RES_CYC(12)) tms_props_inst (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .enable(tms_if_inst.enable),
    .trigger(tms_if_inst.trigger), .dev_rst_n(tms_if_inst.dev_rst_n),
    .start(st), .stop(tms_if_inst.stop), .sclk(tms_if_inst.sclk));
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t: got %0d want %0d", $time, seen, exp);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // clock
  initial
  begin
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  // link pulse counters and hang guard
  always @(posedge sys_clk_i)
  begin
    cyc++;
    st_q <= st;
    tx_q <= tx;
    c[0] += st;
    c[1] += tx;
    c[2] += tx && !tx_q;
    c[3] += st && !st_q;
    c[5] += st && !st_q && !(tx && !tx_q);
    c[4] += tms_if_inst.stop;
    c[6] += fv;
    if (fv)
      ftv = ft;
    if (cyc > 20000)
    begin
      fails++;
      results;
    end
  end
  task rx_pulse;
    @(posedge sys_clk_i) rx <= 1'h1;
    @(posedge sys_clk_i) rx <= 1'h0;
  endtask
  // reset both ends with a new setting and wait until ready
  task write_cfg(input logic [2:0] e, input logic [4:0] n);
    int i;
    @(posedge sys_clk_i) cfg <= {e, n};
    rst_n_i <= 1'h0;
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'h1;
    for (i = 0; i < 500 && rdy !== 1'h1; i++) @(negedge sys_clk_i);
    check(rdy, 1'h1);
  endtask
  // one measurement with an echo arriving after a set delay
  task read_meas(input logic [2:0] e, input logic [4:0] n, input int echo);
    int i;
    int w;
    w = (n > 3 ? 3 : n) << (e + 1);
    write_cfg(e, n);
    c = '{default: 0};
    repeat (8) @(negedge sys_clk_i);
    rx_pulse;
    repeat (4) @(negedge sys_clk_i);
    check(c[3] + c[4], 0);
    @(posedge sys_clk_i) meas <= 1'h1;
    @(posedge sys_clk_i) meas <= 1'h0;
    for (i = 0; i < 50 && busy !== 1'h1; i++) @(negedge sys_clk_i);
    rx_pulse;
    for (i = 0; i < 900 && busy !== 1'h0; i++) @(negedge sys_clk_i);
    check(c[4], 0);
    repeat (echo) @(posedge sys_clk_i);
    rx_pulse;
    for (i = 0; i < 50 && c[6] == 0; i++) @(negedge sys_clk_i);
    check(c[0], w);
    check(c[1], n << e);
    check(c[2], n);
    check(c[3], 1);
    check(c[5], 0);
    check(c[4], 1);
    check(c[6], 1);
    check(ftv > echo, 1'h1);
    $display("test exp %0d count %0d done", e, n);
  endtask
  // settings across count boundaries and exponents
  initial
  begin
    read_meas(3'h2, 5'h01, 20);
    read_meas(3'h2, 5'h02, 9);
    read_meas(3'h2, 5'h03, 30);
    read_meas(3'h2, 5'h05, 12);
    read_meas(3'h1, 5'h1f, 15);
    read_meas(3'h0, 5'h04, 6);
    results;
  end
endmodule
